/* File: include/stc_map.svh */
// register map, field positions, reset values and timing counts of the slow tick block
`ifndef STC_MAP_SVH
`define STC_MAP_SVH

// register indices; byte address is four times the index
`define STC_IDX_ROOT_CLK_DIV 6'h14
`define STC_IDX_AUTO_CLK 6'h15
`define STC_IDX_CLK_EN_RATE 6'h16
`define STC_IDX_CONV_CTRL 6'h18
`define STC_IDX_STATUS 6'h19

// root_clock_divider_config fields
`define STC_BIT_DIV16 14
`define STC_BIT_X4 13
// clock_enable_and_tick_rate fields
`define STC_BIT_HALVE 12
`define STC_BIT_TICK_EN 0
// automatic clock config fields
`define STC_RATIO_MSB 13
`define STC_RATIO_LSB 10
`define STC_FS_MSB 2
`define STC_FS_LSB 0
// conv_ctrl fields
`define STC_BIT_REC_L 0
`define STC_BIT_REC_R 1
`define STC_BIT_PLAY_L 2
`define STC_BIT_PLAY_R 3
`define STC_BIT_PLAY_OSR 4
`define STC_BIT_REC_OSR 5
`define STC_BIT_REC_TST 6
`define STC_BIT_REC_BIAS 7
`define STC_BIT_EQ 8
`define STC_BIT_HR_PLAY 9
`define STC_BIT_HR_REC 10

// reset values
`define STC_RST_ROOT_CLK_DIV 16'h0000
`define STC_RST_CLK_EN_RATE 16'h0000
`define STC_RST_AUTO_CLK 16'h0c05
`define STC_RST_CONV_CTRL 16'h0020

// codes
`define STC_FS_HALF_RATE 3'h5
`define STC_RATIO_128 4'h1

// timing: 256 kHz internal clock from the 10 MHz system clock
`define STC_SYS_CLK_KHZ 10000
`define STC_INT_CLK_KHZ 256
`define STC_ACC_MOD 14'h2710
`define STC_TICK_BASE_DIV 16'h0100
`define STC_TICK_MIN_PERIOD_US 1000
`define STC_TICK_MIN_PERIOD_CYC (`STC_TICK_MIN_PERIOD_US * `STC_SYS_CLK_KHZ / 1000)

`endif

/* File: include/stc_pkg.sv */
// types shared by the slow tick block
package stc_pkg;

	typedef enum logic [1:0] {
		STC_BUS_IDLE = 2'b01,
		STC_BUS_ACK = 2'b10
	} stc_bus_st_t;

	typedef struct packed {
		logic [13:0] acc;
		logic int_pulse;
		logic [14:0] cnt;
		logic tick;
	} stc_div_t;

	typedef struct packed {
		stc_bus_st_t st;
		logic waitreq;
		logic [31:0] rdata;
		logic [15:0] root_div;
		logic [15:0] auto_clk;
		logic [15:0] en_rate;
		logic [15:0] conv;
		logic [7:0] tick_cnt;
		logic play_act;
		logic rec_act;
		logic conflict;
		logic cfg_bad;
		logic mclk_src;
		logic [2:0] fs_code;
		logic fs_reserved;
		logic play_osr_x2;
		logic [3:0] conv_run;
		logic eq_run;
	} stc_top_t;

endpackage

/* File: verilog/stc_tick_div.sv */
// 256 kHz internal clock and programmable slow tick divider
`include "stc_map.svh"

module stc_tick_div #(
	parameter logic [13:0] INT_CLK_STEP = 14'h0100
) (
	input wire logic clk_sys, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic timeout_tick_enable, // runs the chain
	input wire logic tick_halving_select, // 1 = no halving
	input wire logic tick_times_four, // 1 = rate x4
	input wire logic tick_divide_sixteen, // 1 = rate /16
	output logic slow_timeout_tick // one-cycle tick pulse
);

	stc_pkg::stc_div_t state_ff;
	stc_pkg::stc_div_t nxt_state;
	logic [2:0] shift;
	logic [15:0] span;
	logic [14:0] limit;
	logic [14:0] acc_sum;

	// *****************************
	// divider chain
	// *****************************
	always_comb
	begin
		shift = {tick_divide_sixteen, ~tick_times_four, ~tick_halving_select};
		span = `STC_TICK_BASE_DIV << shift;
		limit = 15'(span - 16'h0001);
		acc_sum = {1'b0, state_ff.acc} + {1'b0, INT_CLK_STEP};
		nxt_state = state_ff;
		nxt_state.int_pulse = 1'b0;
		nxt_state.tick = 1'b0;
		// fractional accumulator: 256 kHz on average, jitter of one system cycle
		if (acc_sum >= {1'b0, `STC_ACC_MOD})
		begin
			nxt_state.acc = 14'(acc_sum - {1'b0, `STC_ACC_MOD});
			nxt_state.int_pulse = 1'b1;
		end
		else
			nxt_state.acc = acc_sum[13:0];
		if (state_ff.int_pulse)
		begin
			// >= so a rate change to a shorter period cannot overrun
			if (state_ff.cnt >= limit)
			begin
				nxt_state.cnt = 15'h0000;
				nxt_state.tick = 1'b1;
			end
			else
				nxt_state.cnt = 15'(state_ff.cnt + 15'h0001);
		end
		if (!timeout_tick_enable)
			nxt_state = '0;
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			state_ff <= '0;
		else
			state_ff <= nxt_state;
	end

	assign slow_timeout_tick = state_ff.tick;

	a_div_held: assert property (@(posedge clk_sys) disable iff (!nrst)
		!timeout_tick_enable |=> (state_ff.cnt == 15'h0000) && !state_ff.tick)
		else $error("divider not held while disabled");
	a_fast_rate: assert property (@(posedge clk_sys) disable iff (!nrst)
		(tick_halving_select && tick_times_four && !tick_divide_sixteen) |-> limit == 15'h00ff)
		else $error("fastest rate divide wrong");
	a_slow_rate: assert property (@(posedge clk_sys) disable iff (!nrst)
		(!tick_halving_select && !tick_times_four && tick_divide_sixteen) |-> limit == 15'h7fff)
		else $error("slowest rate divide wrong");
	a_halve_step: assert property (@(posedge clk_sys) disable iff (!nrst)
		(!tick_halving_select && tick_times_four && !tick_divide_sixteen) |-> limit == 15'h01ff)
		else $error("halving select wrong");
	a_x4_scale: assert property (@(posedge clk_sys) disable iff (!nrst)
		(!tick_times_four && !tick_divide_sixteen) |-> limit > 15'h03fe)
		else $error("times four wrong");
	a_div16_scale: assert property (@(posedge clk_sys) disable iff (!nrst)
		tick_divide_sixteen |-> limit > 15'h0ffe)
		else $error("divide sixteen wrong");
	a_tick_cause: assert property (@(posedge clk_sys) disable iff (!nrst)
		state_ff.tick |-> $past(state_ff.int_pulse) && $past(timeout_tick_enable))
		else $error("tick without internal clock pulse");

endmodule // stc_tick_div

/* File: verilog/stc_top.sv */
// slow timeout tick and high-rate converter clocking control with Avalon-MM registers
// Function
// - tick divided from internal 256kHz clock
// - tick runs only while enable bit set
// - halving bit 0 divides tick by two
// - divide-sixteen bit slows tick sixteen times
// - times-four bit speeds tick four times
// - eight rates, 1000Hz down to 7.8125Hz
// - never record and playback both high-rate
// - high rates take core clock from master
// - decode sample rate codes, 110/111 reserved
// - playback high oversample doubles ratio
`include "stc_map.svh"

module stc_top #(
	parameter logic [13:0] INT_CLK_STEP = 14'h0100
) (
	input wire logic clk_sys, // 10 MHz system clock
	input wire logic nrst, // async reset, active low
	input wire logic [7:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte lanes
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // low for one answer cycle
	output logic slow_timeout_tick, // tick pulse to debounce/timeout users
	output logic core_clock_from_mclk, // core clock must come from master clock
	output logic high_rate_playback, // high-rate playback granted
	output logic high_rate_record, // high-rate record granted
	output logic [2:0] sample_rate_code, // decoded sample rate code
	output logic sample_rate_reserved, // software chose a reserved code
	output logic playback_osr_double, // playback oversampling doubled
	output logic [3:0] conv_run, // {right_play, left_play, right_rec, left_rec}
	output logic eq_run // parametric equaliser may run
);

	stc_pkg::stc_top_t state_ff;
	stc_pkg::stc_top_t nxt_state;
	logic [5:0] idx;
	logic aligned;
	logic [15:0] lane_mask;
	logic [15:0] rd_word;
	logic [15:0] status;
	logic tick;
	logic common_bad;

	// *****************************
	// tick divider
	// *****************************
	stc_tick_div #(
		.INT_CLK_STEP(INT_CLK_STEP)
	) u_div (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.timeout_tick_enable(state_ff.en_rate[`STC_BIT_TICK_EN]),
		.tick_halving_select(state_ff.en_rate[`STC_BIT_HALVE]),
		.tick_times_four(state_ff.root_div[`STC_BIT_X4]),
		.tick_divide_sixteen(state_ff.root_div[`STC_BIT_DIV16]),
		.slow_timeout_tick(tick)
	);

	// *****************************
	// next state
	// *****************************
	always_comb
	begin
		idx = avs_address[7:2];
		aligned = (avs_address[1:0] == 2'b00);
		lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
		status = {state_ff.tick_cnt, 2'b00, state_ff.en_rate[`STC_BIT_TICK_EN], state_ff.fs_reserved,
			state_ff.cfg_bad, state_ff.conflict, state_ff.rec_act, state_ff.play_act};
		case (idx)
			`STC_IDX_ROOT_CLK_DIV: rd_word = state_ff.root_div;
			`STC_IDX_AUTO_CLK: rd_word = state_ff.auto_clk;
			`STC_IDX_CLK_EN_RATE: rd_word = state_ff.en_rate;
			`STC_IDX_CONV_CTRL: rd_word = state_ff.conv;
			`STC_IDX_STATUS: rd_word = status;
			default: rd_word = 16'h0000;
		endcase
		if (!aligned)
			rd_word = 16'h0000;
		nxt_state = state_ff;

		// bus slave: one wait cycle, then a single answer cycle
		case (state_ff.st)
			stc_pkg::STC_BUS_IDLE:
			begin
				if (avs_read || avs_write)
				begin
					nxt_state.st = stc_pkg::STC_BUS_ACK;
					nxt_state.waitreq = 1'b0;
					nxt_state.rdata = avs_read ? {16'h0000, rd_word} : 32'h0000_0000;
					if (avs_write && aligned)
					begin
						case (idx)
							`STC_IDX_ROOT_CLK_DIV:
								nxt_state.root_div = (state_ff.root_div & ~lane_mask) | (avs_writedata[15:0] & lane_mask);
							`STC_IDX_AUTO_CLK:
								nxt_state.auto_clk = (state_ff.auto_clk & ~lane_mask) | (avs_writedata[15:0] & lane_mask);
							`STC_IDX_CLK_EN_RATE:
								nxt_state.en_rate = (state_ff.en_rate & ~lane_mask) | (avs_writedata[15:0] & lane_mask);
							`STC_IDX_CONV_CTRL:
								nxt_state.conv = (state_ff.conv & ~lane_mask) | (avs_writedata[15:0] & lane_mask);
							default:
								nxt_state.conv = state_ff.conv;
						endcase
					end
				end
			end
			stc_pkg::STC_BUS_ACK:
			begin
				nxt_state.st = stc_pkg::STC_BUS_IDLE;
				nxt_state.waitreq = 1'b1;
			end
			default:
			begin
				nxt_state.st = stc_pkg::STC_BUS_IDLE;
				nxt_state.waitreq = 1'b1;
			end
		endcase

		// tick counter gives software a view of the tick actually running
		if (tick)
			nxt_state.tick_cnt = 8'(state_ff.tick_cnt + 8'h01);

		// only one path may run at high rate; playback wins a double request
		nxt_state.play_act = state_ff.conv[`STC_BIT_HR_PLAY];
		nxt_state.rec_act = state_ff.conv[`STC_BIT_HR_REC] & ~state_ff.conv[`STC_BIT_HR_PLAY];
		nxt_state.conflict = state_ff.conv[`STC_BIT_HR_REC] & state_ff.conv[`STC_BIT_HR_PLAY];
		nxt_state.mclk_src = state_ff.conv[`STC_BIT_HR_PLAY] | state_ff.conv[`STC_BIT_HR_REC];

		// flag any software setting that the high-rate modes forbid
		common_bad = (state_ff.auto_clk[`STC_FS_MSB:`STC_FS_LSB] != `STC_FS_HALF_RATE)
			|| (state_ff.auto_clk[`STC_RATIO_MSB:`STC_RATIO_LSB] != `STC_RATIO_128)
			|| state_ff.conv[`STC_BIT_EQ];
		nxt_state.cfg_bad = 1'b0;
		if (state_ff.conv[`STC_BIT_HR_PLAY])
			nxt_state.cfg_bad = common_bad || state_ff.conv[`STC_BIT_REC_L]
				|| state_ff.conv[`STC_BIT_REC_R] || state_ff.conv[`STC_BIT_PLAY_OSR];
		else if (state_ff.conv[`STC_BIT_HR_REC])
			nxt_state.cfg_bad = common_bad || state_ff.conv[`STC_BIT_PLAY_L]
				|| state_ff.conv[`STC_BIT_PLAY_R] || state_ff.conv[`STC_BIT_REC_OSR]
				|| state_ff.conv[`STC_BIT_REC_TST] || state_ff.conv[`STC_BIT_REC_BIAS];

		// reserved codes fall back to the half-rate code rather than an undefined rate
		nxt_state.fs_reserved = state_ff.auto_clk[`STC_FS_MSB:`STC_FS_LSB] > `STC_FS_HALF_RATE;
		nxt_state.fs_code = nxt_state.fs_reserved ? `STC_FS_HALF_RATE
			: state_ff.auto_clk[`STC_FS_MSB:`STC_FS_LSB];
		nxt_state.play_osr_x2 = state_ff.conv[`STC_BIT_PLAY_OSR];

		// converters the active high-rate path cannot share are held off
		nxt_state.conv_run = {state_ff.conv[`STC_BIT_PLAY_R], state_ff.conv[`STC_BIT_PLAY_L],
			state_ff.conv[`STC_BIT_REC_R], state_ff.conv[`STC_BIT_REC_L]};
		if (state_ff.conv[`STC_BIT_HR_PLAY])
			nxt_state.conv_run[1:0] = 2'b00;
		else if (state_ff.conv[`STC_BIT_HR_REC])
			nxt_state.conv_run[3:2] = 2'b00;
		nxt_state.eq_run = state_ff.conv[`STC_BIT_EQ]
			& ~(state_ff.conv[`STC_BIT_HR_PLAY] | state_ff.conv[`STC_BIT_HR_REC]);
	end

	// *****************************
	// state register
	// *****************************
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			state_ff <= '0;
			state_ff.st <= stc_pkg::STC_BUS_IDLE;
			state_ff.waitreq <= 1'b1;
			state_ff.root_div <= `STC_RST_ROOT_CLK_DIV;
			state_ff.auto_clk <= `STC_RST_AUTO_CLK;
			state_ff.en_rate <= `STC_RST_CLK_EN_RATE;
			state_ff.conv <= `STC_RST_CONV_CTRL;
			state_ff.fs_code <= `STC_FS_HALF_RATE;
		end
		else
			state_ff <= nxt_state;
	end

	assign avs_readdata = state_ff.rdata;
	assign avs_waitrequest = state_ff.waitreq;
	assign slow_timeout_tick = tick;
	assign core_clock_from_mclk = state_ff.mclk_src;
	assign high_rate_playback = state_ff.play_act;
	assign high_rate_record = state_ff.rec_act;
	assign sample_rate_code = state_ff.fs_code;
	assign sample_rate_reserved = state_ff.fs_reserved;
	assign playback_osr_double = state_ff.play_osr_x2;
	assign conv_run = state_ff.conv_run;
	assign eq_run = state_ff.eq_run;

	// *****************************
	// checks
	// *****************************
	a_tick_gated: assert property (@(posedge clk_sys) disable iff (!nrst)
		(!state_ff.en_rate[`STC_BIT_TICK_EN] && !$past(state_ff.en_rate[`STC_BIT_TICK_EN])) |-> !slow_timeout_tick)
		else $error("tick while disabled");
	a_tick_single: assert property (@(posedge clk_sys) disable iff (!nrst)
		slow_timeout_tick |=> !slow_timeout_tick [*2])
		else $error("tick wider than one cycle");
	a_hr_exclusive: assert property (@(posedge clk_sys) disable iff (!nrst)
		!(high_rate_playback && high_rate_record) && (!high_rate_record || conv_run[3:2] == 2'b00))
		else $error("both high-rate paths active");
	a_mclk_source: assert property (@(posedge clk_sys) disable iff (!nrst)
		(high_rate_playback || high_rate_record) |-> core_clock_from_mclk)
		else $error("high rate without master clock");
	a_fs_decode: assert property (@(posedge clk_sys) disable iff (!nrst)
		sample_rate_reserved |-> (sample_rate_code == `STC_FS_HALF_RATE) && $past(state_ff.auto_clk[2:1] == 2'b11))
		else $error("reserved code decode wrong");
	a_osr_follow: assert property (@(posedge clk_sys) disable iff (!nrst)
		$rose(state_ff.conv[`STC_BIT_PLAY_OSR]) |=> playback_osr_double)
		else $error("playback oversampling not doubled");
	a_eq_block: assert property (@(posedge clk_sys) disable iff (!nrst)
		(high_rate_playback || high_rate_record) && $past(high_rate_playback || high_rate_record) |-> !eq_run)
		else $error("equaliser running at high rate");
	a_bus_answer: assert property (@(posedge clk_sys) disable iff (!nrst)
		(state_ff.st == stc_pkg::STC_BUS_IDLE && (avs_read || avs_write)) |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer timing wrong");

endmodule // stc_top

/* File: verif/stc_top_tb.sv */
// self-checking bench for the slow tick and high-rate clocking block
module stc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// signals and counters
	// ****************************************
	localparam int TIMEOUT = 60000;
	localparam logic [7:0] RA [4] = '{8'h50, 8'h54, 8'h58, 8'h60};
	localparam logic [31:0] RV [4] = '{32'h0000_0000, 32'h0000_0c05, 32'h0000_0000, 32'h0000_0020};
	// tick settings as {halving_select, times_four, divide_sixteen}
	localparam logic [2:0] TC [5] = '{3'b110, 3'b010, 3'b100, 3'b000, 3'b111};
	logic clk_sys;
	logic nrst;
	logic [7:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic slow_timeout_tick;
	logic core_clock_from_mclk;
	logic high_rate_playback;
	logic high_rate_record;
	logic [2:0] sample_rate_code;
	logic sample_rate_reserved;
	logic playback_osr_double;
	logic [3:0] conv_run;
	logic eq_run;
	logic [8:0] outs;
	logic [31:0] rd;
	logic [7:0] c0;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;
	int n;
	assign outs = {core_clock_from_mclk, high_rate_playback, high_rate_record, playback_osr_double, conv_run, eq_run};
	// step 5000 gives one internal pulse every 2 cycles, keeping tick periods short
	stc_top #(.INT_CLK_STEP(14'h1388)) dut (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.slow_timeout_tick(slow_timeout_tick),
		.core_clock_from_mclk(core_clock_from_mclk),
		.high_rate_playback(high_rate_playback),
		.high_rate_record(high_rate_record),
		.sample_rate_code(sample_rate_code),
		.sample_rate_reserved(sample_rate_reserved),
		.playback_osr_double(playback_osr_double),
		.conv_run(conv_run),
		.eq_run(eq_run)
	);
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// ****************************************
	// helper tasks
	// ****************************************
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// outputs are read just after an edge, so they hold the value sampled there
	task automatic wait_ack();
		int k;
		k = 0;
		do
		begin
			@(posedge clk_sys);
			k++;
		end
		while (avs_waitrequest !== 1'b0);
		// answer comes one cycle after the request is taken
		check(32'(k), 32'h2);
	endtask
	task automatic bus_write(input logic [7:0] a, input logic [15:0] d, input logic [3:0] be);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= {16'h0000, d};
		avs_byteenable <= be;
		avs_write <= 1'b1;
		wait_ack();
		avs_write <= 1'b0;
	endtask
	task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_read <= 1'b1;
		wait_ack();
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask
	task automatic settle();
		repeat (3) @(posedge clk_sys);
	endtask
	task automatic count_ticks(input int len, output int c);
		c = 0;
		repeat (len)
		begin
			@(posedge clk_sys);
			if (slow_timeout_tick === 1'b1)
				c++;
		end
	endtask
	// first pass syncs to a tick, second measures tick to tick
	task automatic measure(output int per);
		per = 0;
		for (int i = 0; i < 2; i++)
		begin
			per = 0;
			do
			begin
				@(posedge clk_sys);
				per++;
			end
			while (slow_timeout_tick !== 1'b1 && per < 20000);
		end
	endtask
	task automatic hr(input logic [15:0] c, input logic [8:0] eo, input logic [31:0] es, input logic [31:0] m);
		bus_write(8'h60, c, 4'h3);
		settle();
		check(32'(outs), 32'(eo));
		bus_read(8'h64, rd);
		check(rd & m, es);
	endtask
	function automatic int period(input logic [2:0] c);
		return 512 * (c[2] ? 1 : 2) * (c[1] ? 1 : 4) * (c[0] ? 16 : 1);
	endfunction
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == TIMEOUT)
		begin
			mismatches++;
			stop_test();
		end
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		nrst = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'h0;
		repeat (6) @(posedge clk_sys);
		nrst <= 1'b1;
		settle();
		check(32'(sample_rate_code), 32'h5);
		for (int i = 0; i < 4; i++)
		begin
			bus_read(RA[i], rd);
			check(rd, RV[i]);
		end
		bus_write(8'h50, 16'hffff, 4'h1);
		bus_read(8'h50, rd);
		check(rd, 32'h0000_00ff);
		bus_write(8'h52, 16'h1234, 4'h3);
		bus_read(8'h50, rd);
		check(rd, 32'h0000_00ff);
		bus_read(8'h70, rd);
		check(rd, 32'h0000_0000);
		count_ticks(1200, n);
		check(32'(n), 32'h0);
		// high-rate configurations, status low nibble: play, rec, both, bad
		hr(16'h020c, 9'h198, 32'h9, 32'hf);
		bus_write(8'h54, 16'h0405, 4'h3);
		hr(16'h020c, 9'h198, 32'h1, 32'hf);
		hr(16'h0313, 9'h1a0, 32'h9, 32'hf);
		hr(16'h0407, 9'h146, 32'ha, 32'hf);
		hr(16'h04e3, 9'h146, 32'ha, 32'hf);
		hr(16'h0403, 9'h146, 32'h2, 32'hf);
		bus_write(8'h54, 16'h0404, 4'h3);
		hr(16'h0403, 9'h146, 32'ha, 32'hf);
		hr(16'h0600, 9'h180, 32'h5, 32'h7);
		hr(16'h011f, 9'h03f, 32'h0, 32'h7);
		for (int i = 0; i < 8; i++)
		begin
			bus_write(8'h54, 16'h0c00 | 16'(i), 4'h3);
			settle();
			check(32'(sample_rate_code), (i > 5) ? 32'h5 : 32'(i));
			check(32'(sample_rate_reserved), 32'(i > 5));
			bus_read(8'h64, rd);
			check((rd >> 4) & 32'h1, 32'(i > 5));
		end
		// status is read-only
		bus_write(8'h64, 16'hffff, 4'h3);
		bus_read(8'h64, rd);
		check(rd & 32'h3f, 32'h10);
		// tick rates
		for (int i = 0; i < 5; i++)
		begin
			bus_write(8'h50, {1'b0, TC[i][0], TC[i][1], 13'h0000}, 4'h3);
			bus_write(8'h58, {3'h0, TC[i][2], 12'h001}, 4'h3);
			measure(n);
			check(32'(n), 32'(period(TC[i])));
			// window placed between ticks so the status counter sees exactly the ticks counted here
			if (i == 0)
			begin
				bus_read(8'h64, rd);
				c0 = rd[15:8];
				count_ticks(1800, n);
				check(32'(n), 32'h3);
				bus_read(8'h64, rd);
				check(32'(8'(rd[15:8] - c0)), 32'(n));
			end
		end
		bus_read(8'h64, rd);
		check(rd & 32'h20, 32'h20);
		bus_write(8'h50, 16'h2000, 4'h3);
		bus_write(8'h58, 16'h1000, 4'h3);
		settle();
		count_ticks(1200, n);
		check(32'(n), 32'h0);
		stop_test();
	end
endmodule // stc_top_tb
